// ### mp0_consts.vh
// Purpose: constants for the port 0 media pin block
// Assumes: ref_clk at 100 MHz
// Notes: definitions only
`ifndef MP0_CONSTS_VH
`define MP0_CONSTS_VH
// ****************************************
// port modes
// ****************************************
`define MP0_MODE_MII 2'h0
`define MP0_MODE_GMII 2'h1
`define MP0_MODE_TBI 2'h2
// ****************************************
// timing
// ****************************************
`define MP0_REF_CLK_KHZ 100000
`define MP0_GTX_CLK_KHZ 125000
`define MP0_GTX_HALF_RAW (`MP0_REF_CLK_KHZ / (2 * `MP0_GTX_CLK_KHZ))
`define MP0_GTX_HALF_CYC ((`MP0_GTX_HALF_RAW < 1) ? 1 : `MP0_GTX_HALF_RAW)
`define MP0_EDGE_ARM_CYC 2'h3
// ****************************************
// codes and reset values
// ****************************************
`define MP0_FALSE_CARRIER_GMII 8'h0e
`define MP0_FALSE_CARRIER_MII 4'he
`define MP0_SYNC_WIDTH 16
`define MP0_WORD_RESET 10'h000
`endif

// ### mp0_phy_model.sv
// Purpose: transceiver stand-in for port 0
// Assumes: 125 ns receive and transmit clock period, 250 ns ten-bit clock period
// Notes: data changes midway between capture edges
module mp0_phy_model (
  output reg rx_clk,
  output reg clk_a,
  output reg clk_b,
  output reg tx_clk,
  output reg [7:0] word,
  output reg valid,
  output reg error,
  output reg [9:0] last
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [1:0] ph;
  // ****************************************
  // clocks and receive data
  // ****************************************
  initial begin
    ph = 2'h3;
    {rx_clk, clk_a, tx_clk, word, valid, error, last} = '0;
    clk_b = 1'b1;
    forever begin
      #62.5;
      ph = ph + 2'h1;
      rx_clk = ~ph[0];
      tx_clk = ~ph[0];
      clk_a = ~ph[1];
      clk_b = ph[1];
      if (ph[0]) begin
        {error, valid, word} = 10'($urandom);
        if ($urandom_range(3) == 0) word = 8'h0e;
      end else begin
        last = {error, valid, word};
      end
    end
  end
endmodule // mp0_phy_model

// ### mp0_port.v
// Purpose: media-side pin logic of packet port 0 (MII, GMII, ten-bit)
// Assumes: mode is static while frames run; pins are sampled by ref_clk
// Notes: gigabit clock is a divider of ref_clk
//
// Behaviour
// - ten-bit mode: capture a code group on each rising edge of either clock
// - MII/GMII: receive data sampled on rising receive clock; MII bits 3:0 only
// - ten-bit mode: receive-valid pin is code bit 8, receive-error pin bit 9
// - receive-error with valid is an error; without valid plus data is false carrier
// - carrier sense is asynchronous; in ten-bit mode it is signal present
// - MII launches on PHY transmit clock, bits 3:0; others on own gigabit clock
// - transmit enable rises with first preamble and holds to the last byte
// - transmit error with enable high forces an invalid symbol in the frame
// - ten-bit mode: enable pin carries code bit 8, error pin bit 9
// - GMII and ten-bit modes drive a gigabit transmit clock out
// - only this port offers the gigabit GMII and ten-bit modes
`include "mp0_consts.vh"
module mp0_port #(
  parameter GTX_HALF = `MP0_GTX_HALF_CYC
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [1:0] port_mode,
  input wire port0_phy_rx_clock,
  input wire port0_tbi_rx_clock_a,
  input wire port0_tbi_rx_clock_b,
  input wire port0_collision_in,
  input wire [7:0] port0_receive_word,
  input wire port0_receive_valid,
  input wire port0_receive_error,
  input wire port0_carrier_sense,
  input wire port0_phy_tx_clock,
  output wire [7:0] port0_transmit_word,
  output wire port0_transmit_enable,
  output wire port0_transmit_error,
  output wire port0_gigabit_tx_clock_out,
  input wire [9:0] tx_word,
  input wire tx_frame,
  input wire tx_bad,
  output wire tx_taken,
  output wire [9:0] rx_word,
  output wire rx_strobe,
  output wire rx_valid,
  output wire rx_error,
  output wire rx_false_carrier,
  output wire carrier_present,
  output wire collision_seen
);
  // ****************************************
  // reset release
  // ****************************************
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_int_n;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_int_n = rst_sync_q;

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [15:0] pins_raw;
  wire [15:0] pins_s;
  assign pins_raw = {port0_phy_tx_clock, port0_carrier_sense, port0_receive_error, port0_receive_valid,
    port0_receive_word, port0_collision_in, port0_tbi_rx_clock_b, port0_tbi_rx_clock_a,
    port0_phy_rx_clock};
  mp0_sync #(
    .WIDTH(`MP0_SYNC_WIDTH)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_int_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );
  wire rxc_s = pins_s[0];
  wire rca_s = pins_s[1];
  wire rcb_s = pins_s[2];
  wire col_s = pins_s[3];
  wire [7:0] rxd_s = pins_s[11:4];
  wire rxdv_s = pins_s[12];
  wire rxer_s = pins_s[13];
  wire crs_s = pins_s[14];
  wire txc_s = pins_s[15];

  // ****************************************
  // helpers
  // ****************************************
  function rise;
    input prev;
    input cur;
    begin
      rise = cur & ~prev;
    end
  endfunction

  function [7:0] lane;
    input narrow;
    input [7:0] d;
    begin
      lane = narrow ? {4'h0, d[3:0]} : d;
    end
  endfunction

  function fc_match;
    input wide;
    input [7:0] d;
    begin
      fc_match = wide ? (d == `MP0_FALSE_CARRIER_GMII) : (d[3:0] == `MP0_FALSE_CARRIER_MII);
    end
  endfunction

  wire is_tbi = (port_mode == `MP0_MODE_TBI);
  wire is_gmii = (port_mode == `MP0_MODE_GMII);
  wire is_mii = ~is_tbi & ~is_gmii;

  // ****************************************
  // clock edge detection
  // ****************************************
  reg rxc_prev_q;
  reg rca_prev_q;
  reg rcb_prev_q;
  reg txc_prev_q;
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rxc_prev_q <= 1'b0;
      rca_prev_q <= 1'b0;
      rcb_prev_q <= 1'b0;
      txc_prev_q <= 1'b0;
    end else begin
      rxc_prev_q <= rxc_s;
      rca_prev_q <= rca_s;
      rcb_prev_q <= rcb_s;
      txc_prev_q <= txc_s;
    end
  end
  reg [1:0] arm_cnt_q;
  wire edges_armed = (arm_cnt_q == `MP0_EDGE_ARM_CYC);
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      arm_cnt_q <= 2'h0;
    end else if (!edges_armed) begin
      arm_cnt_q <= arm_cnt_q + 2'h1;
    end
  end
  wire rxc_rise = rise(rxc_prev_q, rxc_s) & edges_armed;
  wire tbi_rise = (rise(rca_prev_q, rca_s) | rise(rcb_prev_q, rcb_s)) & edges_armed;
  wire txc_rise = rise(txc_prev_q, txc_s) & edges_armed;

  // ****************************************
  // receive path
  // ****************************************
  reg [9:0] rx_word_q;
  reg rx_strobe_q;
  reg rx_valid_q;
  reg rx_error_q;
  reg rx_fc_q;
  reg [9:0] rx_word_d;
  reg rx_strobe_d;
  reg rx_valid_d;
  reg rx_error_d;
  reg rx_fc_d;
  wire fc_code = fc_match(is_gmii, rxd_s);
  always @* begin
    rx_word_d = rx_word_q;
    rx_strobe_d = 1'b0;
    rx_valid_d = rx_valid_q;
    rx_error_d = rx_error_q;
    rx_fc_d = rx_fc_q;
    if (is_tbi) begin
      if (tbi_rise) begin
        rx_word_d = {rxer_s, rxdv_s, rxd_s};
        rx_strobe_d = 1'b1;
        rx_valid_d = 1'b1;
        rx_error_d = 1'b0;
        rx_fc_d = 1'b0;
      end
    end else if (rxc_rise) begin
      rx_word_d = {2'h0, lane(~is_gmii, rxd_s)};
      rx_strobe_d = 1'b1;
      rx_valid_d = rxdv_s;
      rx_error_d = rxer_s & rxdv_s;
      rx_fc_d = rxer_s & ~rxdv_s & fc_code;
    end
  end
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rx_word_q <= `MP0_WORD_RESET;
      rx_strobe_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_error_q <= 1'b0;
      rx_fc_q <= 1'b0;
    end else begin
      rx_word_q <= rx_word_d;
      rx_strobe_q <= rx_strobe_d;
      rx_valid_q <= rx_valid_d;
      rx_error_q <= rx_error_d;
      rx_fc_q <= rx_fc_d;
    end
  end

  // ****************************************
  // carrier and collision
  // ****************************************
  reg crs_q;
  reg col_q;
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      crs_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      crs_q <= crs_s;
      col_q <= col_s & ~is_tbi;
    end
  end

  // ****************************************
  // gigabit transmit clock
  // ****************************************
  reg [7:0] gtx_cnt_q;
  reg gtx_q;
  wire gtx_flip = (gtx_cnt_q == GTX_HALF[7:0] - 8'h01);
  wire gtx_launch = gtx_flip & ~gtx_q & ~is_mii;
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      gtx_cnt_q <= 8'h00;
      gtx_q <= 1'b0;
    end else if (is_mii) begin
      gtx_cnt_q <= 8'h00;
      gtx_q <= 1'b0;
    end else if (gtx_flip) begin
      gtx_cnt_q <= 8'h00;
      gtx_q <= ~gtx_q;
    end else begin
      gtx_cnt_q <= gtx_cnt_q + 8'h01;
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  reg [7:0] txd_q;
  reg txen_q;
  reg txer_q;
  reg taken_q;
  reg [7:0] txd_d;
  reg txen_d;
  reg txer_d;
  wire tx_launch = is_mii ? txc_rise : gtx_launch;
  always @* begin
    txd_d = txd_q;
    txen_d = txen_q;
    txer_d = txer_q;
    if (tx_launch) begin
      if (is_tbi) begin
        txd_d = tx_word[7:0];
        txen_d = tx_word[8];
        txer_d = tx_word[9];
      end else begin
        txd_d = lane(is_mii, tx_word[7:0]);
        txen_d = tx_frame;
        txer_d = tx_bad & tx_frame;
      end
    end
  end
  always @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      txd_q <= 8'h00;
      txen_q <= 1'b0;
      txer_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      taken_q <= tx_launch & (tx_frame | is_tbi);
      txd_q <= txd_d;
      txen_q <= txen_d;
      txer_q <= txer_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign port0_transmit_word = txd_q;
  assign port0_transmit_enable = txen_q;
  assign port0_transmit_error = txer_q;
  assign port0_gigabit_tx_clock_out = gtx_q;
  assign tx_taken = taken_q;
  assign rx_word = rx_word_q;
  assign rx_strobe = rx_strobe_q;
  assign rx_valid = rx_valid_q;
  assign rx_error = rx_error_q;
  assign rx_false_carrier = rx_fc_q;
  assign carrier_present = crs_q;
  assign collision_seen = col_q;
endmodule // mp0_port

// ### mp0_port_checker.sv
// Purpose: assertions on the port 0 pin block
// Assumes: GTX_HALF matches the design
// Notes: bound to mp0_port
module mp0_port_checker #(
  parameter int GTX_HALF = 1
) (
  input wire ref_clk,
  input wire rst_n,
  input wire tx_frame,
  input wire tx_bad,
  input wire tx_taken,
  input wire [1:0] port_mode,
  input wire [9:0] tx_word,
  input wire [7:0] port0_transmit_word,
  input wire port0_transmit_enable,
  input wire port0_transmit_error,
  input wire port0_gigabit_tx_clock_out,
  input wire rx_strobe,
  input wire rx_valid,
  input wire rx_error,
  input wire rx_false_carrier,
  input wire port0_carrier_sense,
  input wire carrier_present
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GTX_PER = 2 * GTX_HALF;
  wire mii_m = (port_mode == 2'h0) || (port_mode == 2'h3);
  wire [7:0] tx_lo = tx_word[7:0];
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  taken_has_frame_a: assert property (tx_taken && $past(port_mode) != 2'h2 |-> $past(tx_frame))
    else $error("launch without frame");
  mii_tx_nibble_a: assert property (tx_taken && $past(mii_m) |->
    port0_transmit_word == (8'h0f & $past(tx_lo)))
    else $error("mii transmit nibble wrong");
  gmii_tx_byte_a: assert property (tx_taken && $past(port_mode) == 2'h1 |->
    {port0_transmit_error, port0_transmit_word} == {$past(tx_bad), $past(tx_lo)})
    else $error("gmii transmit byte wrong");
  tbi_tx_code_a: assert property (tx_taken && $past(port_mode) == 2'h2 |->
    {port0_transmit_error, port0_transmit_enable, port0_transmit_word} == $past(tx_word))
    else $error("ten-bit code wrong");
  mii_gtx_idle_a: assert property (port_mode == 2'h0 [*3] |-> !port0_gigabit_tx_clock_out)
    else $error("gigabit clock in mii");
  gtx_period_a: assert property (port_mode == 2'h1 && $rose(port0_gigabit_tx_clock_out) |->
    ##GTX_PER $rose(port0_gigabit_tx_clock_out))
    else $error("gigabit clock period wrong");
  strobe_single_a: assert property (rx_strobe |=> !rx_strobe)
    else $error("strobe too long");
  false_carrier_a: assert property (rx_false_carrier |-> !rx_error && !rx_valid)
    else $error("false carrier without cause");
  carrier_follow_a: assert property (port0_carrier_sense [*8] |-> carrier_present)
    else $error("carrier not seen");
  cover property (tx_taken && port_mode == 2'h2);
  cover property (rx_strobe && rx_false_carrier);
  cover property (tx_taken && port_mode == 2'h1 && port0_transmit_error);
endmodule // mp0_port_checker
bind mp0_port mp0_port_checker #(.GTX_HALF(GTX_HALF)) chk_u (.ref_clk, .rst_n, .tx_frame, .tx_bad,
  .tx_taken, .port_mode, .tx_word, .port0_transmit_word, .port0_transmit_enable, .port0_transmit_error,
  .port0_gigabit_tx_clock_out, .rx_strobe, .rx_valid, .rx_error, .rx_false_carrier,
  .port0_carrier_sense, .carrier_present);

// ### mp0_sync.v
// Purpose: two flip-flop synchroniser for a bundle of pins
// Assumes: each bit is an independent level
// Notes: first stage read only by second stage
module mp0_sync #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // mp0_sync

// ### tb_mp0_port.sv
// Purpose: self-checking bench for the port 0 pin block
// Assumes: ref_clk 100 MHz, receive and transmit clocks 125 ns, ten-bit clocks 250 ns
// Notes: random stimulus, fixed seed
module tb_mp0_port;
  timeunit 1ns;
  timeprecision 100ps;
  reg ref_clk, rst_n, tx_frame, tx_bad, crs, col;
  reg [1:0] port_mode;
  reg [9:0] tx_word;
  reg [12:0] got, msk;
  wire rx_clk, clk_a, clk_b, tx_clk, rv, re, tx_en, tx_er, gtx, tx_taken, rx_strobe;
  wire rx_valid, rx_error, rx_fc, carrier_present, collision_seen;
  wire [7:0] rx_d, tx_d;
  wire [9:0] rx_word, last;
  int bad_count, compares, i, n, m, k;
  mp0_phy_model phy_u (.rx_clk(rx_clk), .clk_a(clk_a), .clk_b(clk_b), .tx_clk(tx_clk),
    .word(rx_d), .valid(rv), .error(re), .last(last));
  mp0_port #(.GTX_HALF(1)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .port_mode(port_mode),
    .port0_phy_rx_clock(rx_clk), .port0_tbi_rx_clock_a(clk_a), .port0_tbi_rx_clock_b(clk_b),
    .port0_collision_in(col), .port0_receive_word(rx_d), .port0_receive_valid(rv),
    .port0_receive_error(re), .port0_carrier_sense(crs), .port0_phy_tx_clock(tx_clk),
    .port0_transmit_word(tx_d), .port0_transmit_enable(tx_en), .port0_transmit_error(tx_er),
    .port0_gigabit_tx_clock_out(gtx), .tx_word(tx_word), .tx_frame(tx_frame), .tx_bad(tx_bad),
    .tx_taken(tx_taken), .rx_word(rx_word), .rx_strobe(rx_strobe), .rx_valid(rx_valid),
    .rx_error(rx_error), .rx_false_carrier(rx_fc), .carrier_present(carrier_present),
    .collision_seen(collision_seen));
  // ****************************************
  // expectations and checks
  // ****************************************
  function automatic [12:0] exp_rx(input [1:0] md, input [9:0] w);
    reg fc;
    begin
      fc = w[9] && !w[8] && ((md == 2'h1) ? (w[7:0] == 8'h0e) : (w[3:0] == 4'he));
      exp_rx = (md == 2'h2) ? {3'h1, w} : {fc, w[9] & w[8], w[8], w};
    end
  endfunction
  function automatic [9:0] exp_tx(input [1:0] md, input [9:0] w, input b);
    exp_tx = (md == 2'h2) ? w : (md == 2'h1) ? {b, 1'b1, w[7:0]} : {b, 5'h10, w[3:0]};
  endfunction
  task automatic chk(input [12:0] g, input [12:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task test_done;
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, tx_frame, tx_bad, crs, col, port_mode, tx_word} = '0;
    bad_count = 0;
    compares = 0;
    void'($urandom(84));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    for (m = 0; m < 4; m++) begin
      port_mode = m[1:0];
      msk = (m == 2) ? 13'h07ff : (m == 1) ? 13'h1cff : 13'h1c0f;
      {crs, col} = m[0] ? 2'h3 : 2'($urandom);
      tx_frame = 1'b1;
      tx_word = 10'($urandom);
      tx_bad = 1'($urandom);
      n = 0;
      k = 0;
      for (i = 0; i < 400 && (n < 24 || k < 8); i++) begin
        @(negedge ref_clk);
        got = {rx_fc, rx_error, rx_valid, rx_word};
        if (rx_strobe === 1'b1 && i > 40) begin
          chk(got & msk, exp_rx(port_mode, last) & msk);
          k++;
        end
        if (tx_taken === 1'b1) begin
          chk({tx_er, tx_en, tx_d}, exp_tx(port_mode, tx_word, tx_bad));
          tx_word = 10'($urandom);
          tx_bad = 1'($urandom);
          n++;
        end
      end
      if (n < 24 || k < 8) begin
        bad_count++;
        break;
      end
      chk(carrier_present, crs);
      chk(collision_seen, col && m != 2);
      tx_frame = 1'b0;
      tx_word = 10'h000;
      for (i = 0; i < 40; i++) begin
        @(negedge ref_clk);
        if (m != 2) chk(tx_taken, 0);
      end
      chk(tx_en, 0);
    end
    test_done;
  end
endmodule // tb_mp0_port
